// ==== include/csfc_pkg.sv ====
// Package: register map, flag layout, commands, states and timing for the status flag block
package csfc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_FLAGS = 6'h00;
  localparam logic [5:0] REG_ACC = 6'h04;
  localparam logic [5:0] REG_OPB = 6'h08;
  localparam logic [5:0] REG_CMD = 6'h0c;
  localparam logic [5:0] REG_SP = 6'h10;
  localparam logic [5:0] REG_HX = 6'h14;
  localparam logic [5:0] REG_PC = 6'h18;
  localparam logic [5:0] REG_IR = 6'h1c;
  localparam logic [5:0] REG_STATE = 6'h20;

  // ----------------------------------------------------------------
  // Flag bit positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_V = 7;
  localparam int BIT_H = 4;
  localparam int BIT_I = 3;
  localparam int BIT_N = 2;
  localparam int BIT_Z = 1;
  localparam int BIT_C = 0;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] STACK_FRAME = 16'h0005;
  localparam logic [15:0] BRK_VECTOR = 16'hfffc;
  localparam logic [15:0] BRK_VECTOR_MON = 16'hfefc;
  localparam logic [7:0] SOFT_TRAP_OPCODE = 8'h00;
  localparam int STACK_DEPTH = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_STAB_NS = 100000;
  localparam int OSC_STAB_CYC = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] OSC_STAB_LAST = 12'(OSC_STAB_CYC - 1);

  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ADD, CMD_ADC, CMD_SUB, CMD_SBC, CMD_AND, CMD_ASL, CMD_LSR,
    CMD_DAA, CMD_CLI, CMD_SEI, CMD_WAIT, CMD_STOP, CMD_AIS, CMD_AIX, CMD_RTI
  } csfc_cmd_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_EXEC2, ST_STACK, ST_VECT, ST_WAIT, ST_STOP, ST_STAB
  } csfc_state_t;

  function automatic logic [15:0] sext16(input logic [7:0] b);
    sext16 = {{8{b[7]}}, b};
  endfunction : sext16
endpackage : csfc_pkg

// ==== hdl/csfc_alu.sv ====
// ALU result and flag generation for the status flag block
`timescale 1ns/1ps
module csfc_alu (
  // Operation
  input wire csfc_pkg::csfc_cmd_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] opb,
  input wire logic [7:0] flags,
  // Outcome
  output logic [7:0] res,
  output logic [7:0] flags_out,
  output logic acc_we
);
  logic [8:0] s9;
  logic [4:0] s5;
  logic cin;
  logic lo_adj;
  logic hi_adj;

  always_comb begin
    s9 = 9'h000;
    s5 = 5'h00;
    lo_adj = 1'b0;
    hi_adj = 1'b0;
    cin = flags[csfc_pkg::BIT_C];
    res = acc;
    flags_out = flags;
    acc_we = 1'b1;
    case (op)
      csfc_pkg::CMD_ADD, csfc_pkg::CMD_ADC: begin
        if (op == csfc_pkg::CMD_ADD) begin
          cin = 1'b0;
        end
        s9 = {1'b0, acc} + {1'b0, opb} + {8'h00, cin};
        s5 = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        res = s9[7:0];
        flags_out[csfc_pkg::BIT_H] = s5[4];
        flags_out[csfc_pkg::BIT_C] = s9[8];
        flags_out[csfc_pkg::BIT_V] = (acc[7] ~^ opb[7]) & (acc[7] ^ s9[7]);
      end
      csfc_pkg::CMD_SUB, csfc_pkg::CMD_SBC: begin
        if (op == csfc_pkg::CMD_SUB) begin
          cin = 1'b0;
        end
        s9 = {1'b0, acc} - {1'b0, opb} - {8'h00, cin};
        res = s9[7:0];
        flags_out[csfc_pkg::BIT_C] = s9[8];
        flags_out[csfc_pkg::BIT_V] = (acc[7] ^ opb[7]) & (acc[7] ^ s9[7]);
      end
      csfc_pkg::CMD_AND: begin
        res = acc & opb;
        flags_out[csfc_pkg::BIT_V] = 1'b0;
      end
      csfc_pkg::CMD_ASL: begin
        res = {acc[6:0], 1'b0};
        flags_out[csfc_pkg::BIT_C] = acc[7];
        flags_out[csfc_pkg::BIT_V] = acc[7] ^ acc[6];
      end
      csfc_pkg::CMD_LSR: begin
        res = {1'b0, acc[7:1]};
        flags_out[csfc_pkg::BIT_C] = acc[0];
        flags_out[csfc_pkg::BIT_V] = acc[0];
      end
      csfc_pkg::CMD_DAA: begin
        lo_adj = flags[csfc_pkg::BIT_H] | (acc[3:0] > 4'h9);
        hi_adj = flags[csfc_pkg::BIT_C] | (acc > 8'h99);
        s9 = {1'b0, acc} + {1'b0, (hi_adj ? 4'h6 : 4'h0), (lo_adj ? 4'h6 : 4'h0)};
        res = s9[7:0];
        flags_out[csfc_pkg::BIT_C] = hi_adj | s9[8];
      end
      default: begin
        acc_we = 1'b0;
      end
    endcase
    if (acc_we) begin
      flags_out[csfc_pkg::BIT_N] = res[7];
      flags_out[csfc_pkg::BIT_Z] = (res == 8'h00);
    end
  end
endmodule : csfc_alu

// ==== hdl/csfc_irq_prio.sv ====
// Fixed priority selection among pending interrupt requests
`timescale 1ns/1ps
module csfc_irq_prio (
  // Requests, line 0 highest
  input wire logic [7:0] req,
  // Winner
  output logic any,
  output logic [2:0] id
);
  always_comb begin
    any = |req;
    id = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        id = 3'(i);
      end
    end
  end
endmodule : csfc_irq_prio

// ==== hdl/csfc_top.sv ====
// Top: status flags, mask sequencing, low power, break entry and stack/index adds
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module csfc_top (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Interrupt and break side
  input wire logic [7:0] IRQ_REQ,
  input wire logic BRK_REQ,
  input wire logic MONITOR_MODE,
  output logic IRQ_ACK,
  output logic [2:0] IRQ_ACK_ID,
  output logic BRK_ACTIVE,
  // CPU clock gate
  output logic CPU_CLK_EN
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] flags_q;
  logic [7:0] acc_q;
  logic [7:0] opb_q;
  logic [15:0] sp_q;
  logic [15:0] hx_q;
  logic [15:0] pc_q;
  logic [7:0] ir_q;
  logic [7:0] imm_q;
  csfc_pkg::csfc_cmd_t exec_q;
  csfc_pkg::csfc_state_t state_q;
  csfc_pkg::csfc_state_t state_d;
  logic [11:0] stab_q;
  logic [7:0] stack_mem [csfc_pkg::STACK_DEPTH];
  logic [2:0] stack_ptr_q;
  logic stack_full_q;
  logic brk_q;
  logic brk_entry_q;
  logic [2:0] irq_id_q;
  logic ack_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic clk_en_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic bus_wr;
  logic bus_rd;
  logic cmd_go;
  logic take_brk;
  logic take_irq;
  logic cmd_ok;
  logic irq_any;
  logic [2:0] irq_id;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_we;
  logic pop_ok;
  csfc_pkg::csfc_cmd_t cmd;

  assign bus_wr = AVS_WRITE & ~wait_q;
  assign bus_rd = AVS_READ & wait_q;
  assign cmd = csfc_pkg::csfc_cmd_t'(AVS_WRITEDATA[3:0]);
  assign cmd_go = bus_wr && (AVS_ADDRESS == csfc_pkg::REG_CMD) && (state_q == csfc_pkg::ST_RUN);
  assign take_brk = BRK_REQ & ~brk_q & (state_q == csfc_pkg::ST_RUN);
  assign take_irq = (state_q == csfc_pkg::ST_RUN) & ~flags_q[csfc_pkg::BIT_I]
                    & irq_any & ~take_brk;
  assign cmd_ok = cmd_go & ~take_brk & ~take_irq;
  assign pop_ok = cmd_ok && (cmd == csfc_pkg::CMD_RTI) && (stack_ptr_q != 3'h0 || stack_full_q);

  csfc_irq_prio u_prio (
    .req(IRQ_REQ),
    .any(irq_any),
    .id(irq_id)
  );

  csfc_alu u_alu (
    .op(cmd),
    .acc(acc_q),
    .opb(opb_q),
    .flags(flags_q),
    .res(alu_res),
    .flags_out(alu_flags),
    .acc_we(alu_we)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      csfc_pkg::ST_RUN: begin
        if (take_brk || take_irq) begin
          state_d = csfc_pkg::ST_STACK;
        end else if (cmd_ok) begin
          case (cmd)
            csfc_pkg::CMD_AIS, csfc_pkg::CMD_AIX: state_d = csfc_pkg::ST_EXEC2;
            csfc_pkg::CMD_WAIT: state_d = csfc_pkg::ST_WAIT;
            csfc_pkg::CMD_STOP: state_d = csfc_pkg::ST_STOP;
            default: state_d = csfc_pkg::ST_RUN;
          endcase
        end
      end
      // Break request waits here until the two-cycle add completes
      csfc_pkg::ST_EXEC2: state_d = csfc_pkg::ST_RUN;
      csfc_pkg::ST_STACK: state_d = csfc_pkg::ST_VECT;
      csfc_pkg::ST_VECT: state_d = csfc_pkg::ST_RUN;
      csfc_pkg::ST_WAIT: begin
        if (irq_any && !flags_q[csfc_pkg::BIT_I]) begin
          state_d = csfc_pkg::ST_STACK;
        end
      end
      csfc_pkg::ST_STOP: begin
        if (irq_any && !flags_q[csfc_pkg::BIT_I]) begin
          state_d = csfc_pkg::ST_STAB;
        end
      end
      csfc_pkg::ST_STAB: begin
        if (stab_q == csfc_pkg::OSC_STAB_LAST) begin
          state_d = csfc_pkg::ST_RUN;
        end
      end
      default: state_d = csfc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_q <= csfc_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Oscillator settling count after stop wake-up
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N || state_q != csfc_pkg::ST_STAB) begin
      stab_q <= 12'h000;
    end else begin
      stab_q <= stab_q + 12'h001;
    end
  end

  // CPU clock is gated while waiting, stopped or settling
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      clk_en_q <= 1'b1;
    end else begin
      clk_en_q <= !(state_d inside {csfc_pkg::ST_WAIT, csfc_pkg::ST_STOP,
                                    csfc_pkg::ST_STAB});
    end
  end

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      flags_q <= csfc_pkg::FLAGS_RESET;
    end else begin
      if (bus_wr && AVS_ADDRESS == csfc_pkg::REG_FLAGS) begin
        // Direct writes may set the mask but never clear it
        flags_q <= AVS_WRITEDATA[7:0] | csfc_pkg::FLAGS_ONES
                   | {4'h0, flags_q[csfc_pkg::BIT_I], 3'h0};
      end
      if (state_q == csfc_pkg::ST_STACK) begin
        flags_q[csfc_pkg::BIT_I] <= 1'b1;
      end
      if (cmd_ok) begin
        case (cmd)
          csfc_pkg::CMD_CLI: flags_q[csfc_pkg::BIT_I] <= 1'b0;
          csfc_pkg::CMD_SEI: flags_q[csfc_pkg::BIT_I] <= 1'b1;
          csfc_pkg::CMD_WAIT: flags_q[csfc_pkg::BIT_I] <= 1'b0;
          csfc_pkg::CMD_STOP: flags_q[csfc_pkg::BIT_I] <= 1'b0;
          csfc_pkg::CMD_RTI: begin
            if (pop_ok) begin
              flags_q <= stack_mem[stack_ptr_q - 3'h1] | csfc_pkg::FLAGS_ONES;
            end
          end
          default: begin
            if (alu_we) begin
              flags_q <= alu_flags | csfc_pkg::FLAGS_ONES;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and operand
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      acc_q <= csfc_pkg::ACC_RESET;
    end else if (cmd_ok && alu_we) begin
      acc_q <= alu_res;
    end else if (bus_wr && AVS_ADDRESS == csfc_pkg::REG_ACC) begin
      acc_q <= AVS_WRITEDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      opb_q <= 8'h00;
    end else if (bus_wr && AVS_ADDRESS == csfc_pkg::REG_OPB) begin
      opb_q <= AVS_WRITEDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Two-cycle immediate adds
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      exec_q <= csfc_pkg::CMD_NOP;
      imm_q <= 8'h00;
    end else if (cmd_ok) begin
      exec_q <= cmd;
      imm_q <= opb_q;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      sp_q <= csfc_pkg::SP_RESET;
    end else if (state_q == csfc_pkg::ST_EXEC2 && exec_q == csfc_pkg::CMD_AIS) begin
      sp_q <= sp_q + csfc_pkg::sext16(imm_q);
    end else if (state_q == csfc_pkg::ST_STACK) begin
      // Frame holds flags, A, X and PC; the index high byte is left to software
      sp_q <= sp_q - csfc_pkg::STACK_FRAME;
    end else if (pop_ok) begin
      sp_q <= sp_q + csfc_pkg::STACK_FRAME;
    end else if (bus_wr && AVS_ADDRESS == csfc_pkg::REG_SP) begin
      sp_q <= AVS_WRITEDATA[15:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      hx_q <= 16'h0000;
    end else if (state_q == csfc_pkg::ST_EXEC2 && exec_q == csfc_pkg::CMD_AIX) begin
      hx_q <= hx_q + csfc_pkg::sext16(imm_q);
    end else if (bus_wr && AVS_ADDRESS == csfc_pkg::REG_HX) begin
      hx_q <= AVS_WRITEDATA[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Saved flag stack
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      stack_ptr_q <= 3'h0;
      stack_full_q <= 1'b0;
    end else if (state_q == csfc_pkg::ST_STACK) begin
      // Oldest frame is overwritten once the stack wraps
      stack_mem[stack_ptr_q] <= flags_q;
      stack_ptr_q <= stack_ptr_q + 3'h1;
      stack_full_q <= stack_full_q | (stack_ptr_q == 3'h7);
    end else if (pop_ok) begin
      stack_ptr_q <= stack_ptr_q - 3'h1;
      stack_full_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and break entry
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      brk_q <= 1'b0;
      brk_entry_q <= 1'b0;
      pc_q <= 16'h0000;
      ir_q <= 8'h00;
    end else if (take_brk) begin
      brk_q <= 1'b1;
      brk_entry_q <= 1'b1;
      ir_q <= csfc_pkg::SOFT_TRAP_OPCODE;
      pc_q <= MONITOR_MODE ? csfc_pkg::BRK_VECTOR_MON : csfc_pkg::BRK_VECTOR;
    end else begin
      if (state_q == csfc_pkg::ST_VECT) begin
        brk_entry_q <= 1'b0;
      end
      if (pop_ok && brk_q && !BRK_REQ) begin
        brk_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      irq_id_q <= 3'h0;
    end else if (state_q == csfc_pkg::ST_STACK) begin
      irq_id_q <= irq_id;
    end
  end

  // One-cycle acknowledge during the vector step of a maskable entry
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (state_q == csfc_pkg::ST_STACK) && !brk_entry_q;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      wait_q <= 1'b1;
    end else if (wait_q) begin
      wait_q <= ~(AVS_READ | AVS_WRITE);
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_rd) begin
      case (AVS_ADDRESS)
        csfc_pkg::REG_FLAGS: rdata_q <= {24'h00_0000, flags_q | csfc_pkg::FLAGS_ONES};
        csfc_pkg::REG_ACC: rdata_q <= {24'h00_0000, acc_q};
        csfc_pkg::REG_OPB: rdata_q <= {24'h00_0000, opb_q};
        csfc_pkg::REG_CMD: rdata_q <= {28'h000_0000, exec_q};
        csfc_pkg::REG_SP: rdata_q <= {16'h0000, sp_q};
        csfc_pkg::REG_HX: rdata_q <= {16'h0000, hx_q};
        csfc_pkg::REG_PC: rdata_q <= {16'h0000, pc_q};
        csfc_pkg::REG_IR: rdata_q <= {24'h00_0000, ir_q};
        csfc_pkg::REG_STATE: rdata_q <= {20'h0_0000, stack_full_q, stack_ptr_q,
                                         brk_q, irq_id_q, 1'b0, state_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ_ACK = ack_q;
  assign IRQ_ACK_ID = irq_id_q;
  assign BRK_ACTIVE = brk_q;
  assign CPU_CLK_EN = clk_en_q;
endmodule : csfc_top

// ==== test/csfc_top_sva.sv ====
// Checker: port-level properties of the status flag block
`timescale 1ns/1ps
module csfc_top_sva (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Register bus
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  // Interrupt, break and clock gate
  input wire logic [7:0] IRQ_REQ,
  input wire logic BRK_REQ,
  input wire logic IRQ_ACK,
  input wire logic [2:0] IRQ_ACK_ID,
  input wire logic BRK_ACTIVE,
  input wire logic CPU_CLK_EN
);
  localparam int WAKE_MAX = 4100;
  logic [12:0] slp_q;
  logic sleep_cmd;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  function automatic logic [2:0] top_req(input logic [7:0] r);
    top_req = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (r[i]) top_req = 3'(i);
    end
  endfunction : top_req
  // Wait (0xb) or stop (0xc) command landing
  assign sleep_cmd = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == csfc_pkg::REG_CMD
    && AVS_WRITEDATA[3:0] inside {4'hb, 4'hc};
  // Cycles asleep with a request pending; bounds the settling delay
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N || CPU_CLK_EN || IRQ_REQ == 8'h00) begin
      slp_q <= 13'h0000;
    end else if (slp_q != 13'h1fff) begin
      slp_q <= slp_q + 13'h0001;
    end
  end
  wreq_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus access not answered in one cycle");
  reset_vals_a: assert property (disable iff (1'b0) !RESET_N |=>
    AVS_WAITREQUEST && !IRQ_ACK && !BRK_ACTIVE && CPU_CLK_EN)
    else $error("outputs not at reset values");
  ack_pulse_a: assert property (IRQ_ACK |=> !IRQ_ACK)
    else $error("interrupt acknowledge longer than one cycle");
  ack_prio_a: assert property (IRQ_ACK && $past(IRQ_REQ) != 8'h00 |->
    IRQ_ACK_ID == top_req($past(IRQ_REQ)))
    else $error("served request is not the highest priority");
  brk_hold_a: assert property (BRK_ACTIVE && BRK_REQ |=> BRK_ACTIVE)
    else $error("break ended while request still high");
  brk_entry_a: assert property ($rose(BRK_ACTIVE) |-> $past(BRK_REQ))
    else $error("break entered without a request");
  sleep_gate_a: assert property (sleep_cmd |-> ##[1:2] !CPU_CLK_EN)
    else $error("cpu clock not stopped by sleep command");
  wake_bound_a: assert property (slp_q < WAKE_MAX)
    else $error("wake from sleep took too long");
  cover property (IRQ_ACK);
  cover property ($rose(BRK_ACTIVE));
  cover property ($fell(CPU_CLK_EN));
endmodule : csfc_top_sva

bind csfc_top csfc_top_sva csfc_top_sva_inst (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ_REQ(IRQ_REQ),
  .BRK_REQ(BRK_REQ), .IRQ_ACK(IRQ_ACK), .IRQ_ACK_ID(IRQ_ACK_ID), .BRK_ACTIVE(BRK_ACTIVE),
  .CPU_CLK_EN(CPU_CLK_EN));

// ==== test/tb.sv ====
// Testbench: bus-driven checks of flags, mask, low power and break entry
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] irq = 8'h00;
  logic brk = 1'b0;
  logic mon = 1'b0;
  logic [31:0] rdata, v;
  logic wreq, ack, brk_act, clk_en;
  logic [2:0] ack_id;
  logic [35:0] e;
  // Entries: command, acc, operand, expected acc, expected flags
  logic [35:0] alu_tab [12] = '{36'h1_01_01_02_68, 36'h3_00_01_ff_6d, 36'h4_10_0f_00_6a,
    36'h2_0f_01_10_78, 36'h1_7f_01_80_fc, 36'h1_ff_01_00_7b, 36'h5_f0_0f_00_7b,
    36'h6_81_00_02_f9, 36'h7_01_00_00_fb, 36'h1_09_01_0a_68, 36'h8_0a_00_10_68,
    36'h0_55_00_55_68};
  int miscompares = 0;
  int checks_done = 0;
  int acks = 0;
  int n;
  always #12.5 clk = ~clk;
  csfc_top csfc_top_inst (.SYS_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .IRQ_REQ(irq), .BRK_REQ(brk), .MONITOR_MODE(mon), .IRQ_ACK(ack), .IRQ_ACK_ID(ack_id),
    .BRK_ACTIVE(brk_act), .CPU_CLK_EN(clk_en));
  always @(posedge clk) begin
    if (ack === 1'b1) acks++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, v);
  endtask : rd_chk
  task automatic cmd(input csfc_pkg::csfc_cmd_t c);
    bus(1'b1, csfc_pkg::REG_CMD, 32'(c));
  endtask : cmd
  task automatic until_high(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : until_high

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h68);
    rd_chk("sp", csfc_pkg::REG_SP, 32'h00ff);
    rd_chk("unmapped", 6'h24, 32'h0);
    bus(1'b1, csfc_pkg::REG_FLAGS, 32'h0);
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h68);
    foreach (alu_tab[i]) begin
      e = alu_tab[i];
      bus(1'b1, csfc_pkg::REG_ACC, 32'(e[31:24]));
      bus(1'b1, csfc_pkg::REG_OPB, 32'(e[23:16]));
      bus(1'b1, csfc_pkg::REG_CMD, 32'(e[35:32]));
      rd_chk("acc", csfc_pkg::REG_ACC, 32'(e[15:8]));
      rd_chk("flags", csfc_pkg::REG_FLAGS, 32'(e[7:0]));
    end
    bus(1'b1, csfc_pkg::REG_SP, 32'h0100);
    bus(1'b1, csfc_pkg::REG_OPB, 32'hfe);
    cmd(csfc_pkg::CMD_AIS);
    rd_chk("sp", csfc_pkg::REG_SP, 32'h00fe);
    bus(1'b1, csfc_pkg::REG_HX, 32'h1234);
    bus(1'b1, csfc_pkg::REG_OPB, 32'h80);
    cmd(csfc_pkg::CMD_AIX);
    rd_chk("hx", csfc_pkg::REG_HX, 32'h11b4);
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h68);
    irq <= 8'h06;
    repeat (10) @(posedge clk);
    chk("masked acks", 32'h0, 32'(acks));
    cmd(csfc_pkg::CMD_CLI);
    until_high(ack, 20);
    chk("ack id", 32'h1, 32'(ack_id));
    irq <= 8'h00;
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h68);
    cmd(csfc_pkg::CMD_RTI);
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h60);
    cmd(csfc_pkg::CMD_SEI);
    cmd(csfc_pkg::CMD_WAIT);
    // Gate drops at the landing edge; look one edge later
    @(posedge clk);
    chk("clk en", 32'h0, 32'(clk_en));
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h60);
    irq <= 8'h80;
    until_high(ack, 20);
    chk("ack id", 32'h7, 32'(ack_id));
    irq <= 8'h00;
    cmd(csfc_pkg::CMD_RTI);
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h60);
    chk("clk en", 32'h1, 32'(clk_en));
    cmd(csfc_pkg::CMD_SEI);
    cmd(csfc_pkg::CMD_STOP);
    irq <= 8'h10;
    @(posedge clk);
    until_high(clk_en, 5000);
    chk("settle", 32'h1, 32'(n >= csfc_pkg::OSC_STAB_CYC - 1 && n < csfc_pkg::OSC_STAB_CYC + 10));
    until_high(ack, 20);
    chk("ack id", 32'h4, 32'(ack_id));
    irq <= 8'h00;
    cmd(csfc_pkg::CMD_RTI);
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h60);
    for (int m = 0; m < 2; m++) begin
      // Second pass raises the break during a two-cycle add
      if (m == 1) begin
        cmd(csfc_pkg::CMD_AIS);
      end
      mon <= m[0];
      brk <= 1'b1;
      until_high(brk_act, 20);
      chk("break delay", 32'(2 + m), 32'(n));
      brk <= 1'b0;
      rd_chk("pc", csfc_pkg::REG_PC, 32'(m[0] ? csfc_pkg::BRK_VECTOR_MON : csfc_pkg::BRK_VECTOR));
      rd_chk("ir", csfc_pkg::REG_IR, 32'(csfc_pkg::SOFT_TRAP_OPCODE));
      cmd(csfc_pkg::CMD_RTI);
      repeat (2) @(posedge clk);
      chk("break end", 32'h0, 32'(brk_act));
    end
    // ----------------------------------------------------------------
    // Reset while waiting
    // ----------------------------------------------------------------
    cmd(csfc_pkg::CMD_WAIT);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("clk en", 32'h1, 32'(clk_en));
    rd_chk("flags", csfc_pkg::REG_FLAGS, 32'h68);
    rd_chk("state", csfc_pkg::REG_STATE, 32'h0);
    conclude();
  end
  initial begin
    #(25ns * 20000);
    miscompares++;
    $display("[FAIL] watchdog expected finish seen timeout");
    conclude();
  end
endmodule : tb
